// file: src/bltf_framer.v
/*
  backplane link-training framer: serial transmit of training frames,
  frame-lock hunt and control-channel decode on receive, axi4-lite slave.
  assumes one line bit per aclk cycle on tx_line and rx_line, rx_line
  arriving from a pin, tech_ready driven by negotiation logic on aclk.
*/
// Implementation choices: register access over AXI4-Lite and the register addresses.
// Contract
// [RULE1] start training only once a backplane technology has been selected
// [RULE2] each transmitted frame is exactly 4384 bits long
// [RULE3] order: marker, update field, status field, training sequence
// [RULE4] marker is sixteen ones then sixteen zeros, unique in the frame
// [RULE5] each control field spans 128 line bits, carrying 16 bits
// [RULE6] control field bits go out from bit 15 down to bit 0
// [RULE7] manchester cell clock runs at a quarter of the line rate
// [RULE8] reserved control bits sent as zero and ignored on receive
// [RULE9] update bit 13 requests coefficient preset
// [RULE10] update bit 12 requests coefficient initialization
// [RULE11] three 2-bit tap requests: hold, increment, decrement, reserved
// [RULE12] three 2-bit tap status: not updated, updated, minimum, maximum
// [RULE13] status bit 15 high means receiver ready, training done
// [RULE14] training sequence is 4094 pseudo-random bits then two zeros
// [RULE15] pseudo-random bits go out at the full line rate
// [RULE16] generator loads an external 11-bit seed then free-runs
// [RULE17] generator polynomial is 1 + x^9 + x^11
// [RULE18] control bits must stay stable 288 bit times after frame start
// [RULE19] receiver hunts for the marker and raises frame lock
// [RULE20] received update and status fields appear with transmit layout
// [RULE21] on manchester error keep last good fields until a clean frame
`timescale 1ns/1ns
`include "bltf_consts.vh"

module bltf_framer #(
  parameter LOCK_HITS = `BLTF_LOCK_HITS,
  parameter LOSS_MISS = `BLTF_LOSS_MISS
) (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire tech_ready,
  output reg tx_line,
  output reg tx_sof,
  input wire rx_line,
  output reg frame_lock,
  output reg [15:0] rx_update,
  output reg [15:0] rx_status,
  output reg rx_dme_err
);

  // software-visible state
  reg ctrl_en_r;
  reg [15:0] tx_upd_r;
  reg [15:0] tx_sts_r;
  reg [10:0] seed_r;
  reg dme_err_sticky_r;

  // axi write holding
  reg aw_full_r;
  reg [7:0] awaddr_r;
  reg w_full_r;
  reg [31:0] wdata_r;
  reg [3:0] wstrb_r;
  wire do_write;
  wire [31:0] wmask;
  wire aw_take;
  wire w_take;
  wire ar_take;
  wire err_clr;

  // transmitter state
  reg tx_run_r;
  reg [12:0] tx_cnt_r;
  reg [31:0] tx_word_r;
  reg [10:0] prbs_r;
  reg dme_lvl_r;
  reg dme_lvl_nxt;
  reg tx_bit_nxt;
  wire tx_go;
  wire [12:0] tx_pos;
  wire [4:0] tx_cell;
  wire tx_data_bit;
  wire prbs_fb;

  // receiver state
  reg rx_meta_r;
  reg rx_sync_r;
  reg [31:0] rx_sr_r;
  reg hunting_r;
  reg [12:0] rx_cnt_r;
  reg [1:0] hit_cnt_r;
  reg [1:0] miss_cnt_r;
  reg [31:0] rx_word_r;
  reg frame_bad_r;
  reg half_lvl_r;
  reg prev_lvl_r;
  reg cell_a_r;
  wire marker_hit;
  wire [12:0] rx_pos;
  wire [2:0] rx_phase;
  wire rx_in_ctl;

  assign tx_go = ctrl_en_r & tech_ready; // RULE1

  // byte-lane mask built from the held strobes
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_lane
      assign wmask[gi*8 +: 8] = {8{wstrb_r[gi]}};
    end
  endgenerate

  // axi handshakes; writes stall while a response is pending
  assign s_axi_awready = ~aw_full_r & ~s_axi_bvalid;
  assign s_axi_wready = ~w_full_r & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take = s_axi_wvalid & s_axi_wready;
  assign ar_take = s_axi_arvalid & s_axi_arready;
  assign do_write = aw_full_r & w_full_r & ~s_axi_bvalid;
  assign err_clr = do_write & (awaddr_r == `BLTF_OFF_STATUS) & wstrb_r[0] &
                   wdata_r[`BLTF_ST_DMEERR];

  // write channel: address and data taken in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      awaddr_r <= 8'h00;
      w_full_r <= 1'b0;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `BLTF_RESP_OKAY;
      ctrl_en_r <= 1'b0;
      tx_upd_r <= 16'h0000;
      tx_sts_r <= 16'h0000;
      seed_r <= `BLTF_SEED_RST;
    end else begin
      if (aw_take) begin
        aw_full_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (w_take) begin
        w_full_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_full_r <= 1'b0;
        w_full_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `BLTF_RESP_OKAY;
        case (awaddr_r)
          `BLTF_OFF_CTRL: begin
            if (wstrb_r[0]) begin
              ctrl_en_r <= wdata_r[0];
            end
          end
          `BLTF_OFF_TX_UPD: begin
            // reserved update bits forced to zero
            tx_upd_r <= ((tx_upd_r & ~wmask[15:0]) | (wdata_r[15:0] & wmask[15:0])) &
                        `BLTF_UPD_MASK; // RULE8
          end
          `BLTF_OFF_TX_STS: begin
            tx_sts_r <= ((tx_sts_r & ~wmask[15:0]) | (wdata_r[15:0] & wmask[15:0])) &
                        `BLTF_STS_MASK; // RULE8
          end
          `BLTF_OFF_SEED: begin
            seed_r <= ((seed_r & ~wmask[10:0]) | (wdata_r[10:0] & wmask[10:0])) &
                      `BLTF_SEED_MASK;
          end
          `BLTF_OFF_STATUS: begin
            s_axi_bresp <= `BLTF_RESP_OKAY;
          end
          `BLTF_OFF_RX_UPD, `BLTF_OFF_RX_STS: begin
            s_axi_bresp <= `BLTF_RESP_OKAY;
          end
          default: begin
            s_axi_bresp <= `BLTF_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read channel, one cycle to data
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `BLTF_RESP_OKAY;
    end else if (ar_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `BLTF_RESP_OKAY;
      case (s_axi_araddr)
        `BLTF_OFF_CTRL: s_axi_rdata <= {31'h00000000, ctrl_en_r};
        `BLTF_OFF_TX_UPD: s_axi_rdata <= {16'h0000, tx_upd_r};
        `BLTF_OFF_TX_STS: s_axi_rdata <= {16'h0000, tx_sts_r};
        `BLTF_OFF_SEED: s_axi_rdata <= {21'h000000, seed_r};
        `BLTF_OFF_STATUS: s_axi_rdata <= {28'h0000000, tech_ready, dme_err_sticky_r,
                                          tx_run_r, frame_lock};
        `BLTF_OFF_RX_UPD: s_axi_rdata <= {16'h0000, rx_update};
        `BLTF_OFF_RX_STS: s_axi_rdata <= {16'h0000, rx_status};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `BLTF_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // transmit field geometry: 8 line bits per control bit, 4 per half cell
  assign tx_pos = tx_cnt_r - `BLTF_MARK_END;
  assign tx_cell = tx_pos[7:3];
  assign tx_data_bit = tx_word_r[5'd31 - tx_cell]; // RULE6
  assign prbs_fb = prbs_r[10] ^ prbs_r[8]; // RULE17

  // next line bit from the frame position
  always @* begin
    dme_lvl_nxt = dme_lvl_r;
    tx_bit_nxt = 1'b0;
    if (tx_cnt_r < `BLTF_MARK_ONES) begin
      tx_bit_nxt = 1'b1; // RULE4
    end else if (tx_cnt_r < `BLTF_MARK_END) begin
      tx_bit_nxt = 1'b0; // RULE4
    end else if (tx_cnt_r < `BLTF_CTL_END) begin
      // transition at every cell edge, extra mid-cell transition for a one
      if (tx_pos[2:0] == 3'd0) begin
        dme_lvl_nxt = ~dme_lvl_r; // RULE7
      end else if (tx_pos[2:0] == 3'd4 && tx_data_bit) begin
        dme_lvl_nxt = ~dme_lvl_r; // RULE7
      end
      tx_bit_nxt = dme_lvl_nxt; // RULE5
    end else if (tx_cnt_r < `BLTF_PRBS_END) begin
      tx_bit_nxt = prbs_r[10]; // RULE15
    end else begin
      tx_bit_nxt = 1'b0; // RULE14
    end
  end

  // frame sequencer; a dropped enable stops the line at once
  always @(posedge aclk) begin
    if (!aresetn) begin
      tx_run_r <= 1'b0;
      tx_cnt_r <= 13'd0;
      tx_word_r <= 32'h00000000;
      prbs_r <= `BLTF_SEED_RST;
      dme_lvl_r <= 1'b0;
      tx_line <= 1'b0;
      tx_sof <= 1'b0;
    end else begin
      tx_sof <= 1'b0;
      if (!tx_go) begin
        tx_run_r <= 1'b0;
        tx_cnt_r <= 13'd0;
        tx_line <= 1'b0;
      end else begin
        tx_run_r <= 1'b1;
        tx_line <= tx_bit_nxt;
        dme_lvl_r <= dme_lvl_nxt;
        if (tx_cnt_r == 13'd0) begin
          tx_sof <= 1'b1;
          // snapshot keeps the fields steady while they are on the line
          tx_word_r <= {tx_upd_r, tx_sts_r}; // RULE18 RULE3
        end
        if (tx_cnt_r == `BLTF_MARK_END - 13'd1) begin
          dme_lvl_r <= 1'b0; // marker ends low, first cell edge goes high
        end
        if (!tx_run_r) begin
          // zero seed would lock the generator, so fall back to all ones
          prbs_r <= (seed_r == 11'h000) ? `BLTF_SEED_RST : seed_r; // RULE16
        end else if (tx_cnt_r >= `BLTF_CTL_END && tx_cnt_r < `BLTF_PRBS_END) begin
          prbs_r <= {prbs_r[9:0], prbs_fb}; // RULE16 RULE17
        end
        if (tx_cnt_r == `BLTF_FRAME_BITS - 13'd1) begin
          tx_cnt_r <= 13'd0; // RULE2
        end else begin
          tx_cnt_r <= tx_cnt_r + 13'd1;
        end
      end
    end
  end

  // pin synchroniser, only the second stage is read
  always @(posedge aclk) begin
    if (!aresetn) begin
      rx_meta_r <= 1'b0;
      rx_sync_r <= 1'b0;
      rx_sr_r <= 32'h00000000;
    end else begin
      rx_meta_r <= rx_line;
      rx_sync_r <= rx_meta_r;
      rx_sr_r <= {rx_sr_r[30:0], rx_sync_r};
    end
  end

  // rx_cnt_r labels the bit now held in rx_sr_r[0]
  assign marker_hit = (rx_sr_r == `BLTF_MARKER);
  assign rx_pos = rx_cnt_r - `BLTF_MARK_END;
  assign rx_phase = rx_pos[2:0];
  assign rx_in_ctl = ~hunting_r & (rx_cnt_r >= `BLTF_MARK_END) & (rx_cnt_r < `BLTF_CTL_END);

  // frame alignment: hunt, confirm at the expected position, drop on misses
  always @(posedge aclk) begin
    if (!aresetn) begin
      hunting_r <= 1'b1;
      rx_cnt_r <= 13'd0;
      hit_cnt_r <= 2'd0;
      miss_cnt_r <= 2'd0;
      frame_lock <= 1'b0;
    end else if (hunting_r) begin
      if (marker_hit) begin
        hunting_r <= 1'b0; // RULE19
        rx_cnt_r <= `BLTF_MARK_END;
        hit_cnt_r <= 2'd1;
        miss_cnt_r <= 2'd0;
      end
    end else begin
      if (rx_cnt_r == `BLTF_FRAME_BITS - 13'd1) begin
        rx_cnt_r <= 13'd0;
      end else begin
        rx_cnt_r <= rx_cnt_r + 13'd1;
      end
      if (rx_cnt_r == `BLTF_MARK_END - 13'd1) begin
        if (marker_hit) begin
          miss_cnt_r <= 2'd0;
          if (hit_cnt_r != 2'd3) begin
            hit_cnt_r <= hit_cnt_r + 2'd1;
          end
          if (hit_cnt_r + 2'd1 >= LOCK_HITS[1:0]) begin
            frame_lock <= 1'b1; // RULE19
          end
        end else if (!frame_lock || miss_cnt_r + 2'd1 >= LOSS_MISS[1:0]) begin
          hunting_r <= 1'b1; // RULE19
          frame_lock <= 1'b0;
          hit_cnt_r <= 2'd0;
          miss_cnt_r <= 2'd0;
        end else begin
          miss_cnt_r <= miss_cnt_r + 2'd1;
        end
      end
    end
  end

  // manchester decode over the two control fields
  always @(posedge aclk) begin
    if (!aresetn) begin
      rx_word_r <= 32'h00000000;
      frame_bad_r <= 1'b0;
      half_lvl_r <= 1'b0;
      prev_lvl_r <= 1'b0;
      cell_a_r <= 1'b0;
      rx_update <= 16'h0000;
      rx_status <= 16'h0000;
      rx_dme_err <= 1'b0;
    end else begin
      rx_dme_err <= 1'b0;
      // decode reads rx_sr_r[0], the bit that rx_cnt_r labels
      if (!rx_in_ctl) begin
        frame_bad_r <= 1'b0;
        prev_lvl_r <= rx_sr_r[0];
      end else begin
        if (rx_phase == 3'd0) begin
          half_lvl_r <= rx_sr_r[0];
          cell_a_r <= rx_sr_r[0];
          if (rx_sr_r[0] == prev_lvl_r) begin
            frame_bad_r <= 1'b1; // missing cell-edge transition
          end
        end else if (rx_phase == 3'd4) begin
          half_lvl_r <= rx_sr_r[0];
          rx_word_r <= {rx_word_r[30:0], rx_sr_r[0] ^ cell_a_r}; // RULE6
        end else if (rx_sr_r[0] != half_lvl_r) begin
          frame_bad_r <= 1'b1; // level moved inside a half cell
        end
        if (rx_phase == 3'd7) begin
          prev_lvl_r <= rx_sr_r[0];
        end
        if (rx_cnt_r == `BLTF_CTL_END - 13'd1) begin
          if (frame_bad_r || rx_sr_r[0] != half_lvl_r) begin
            rx_dme_err <= 1'b1; // RULE21
          end else begin
            // word complete since the last mid-cell sample; reserved positions dropped
            rx_update <= rx_word_r[31:16] & `BLTF_UPD_MASK; // RULE20 RULE8 RULE9 RULE10 RULE11
            rx_status <= rx_word_r[15:0] & `BLTF_STS_MASK; // RULE20 RULE12 RULE13
          end
        end
      end
    end
  end

  // sticky error for software; a new error wins over a clear
  always @(posedge aclk) begin
    if (!aresetn) begin
      dme_err_sticky_r <= 1'b0;
    end else if (rx_dme_err) begin
      dme_err_sticky_r <= 1'b1;
    end else if (err_clr) begin
      dme_err_sticky_r <= 1'b0;
    end
  end

endmodule // bltf_framer

// file: include/bltf_consts.vh
/*
  constants for the backplane training framer: register offsets, field
  positions, reset values and frame timing counts.
  assumes inclusion by bare name from the design file, after `timescale.
*/
`ifndef BLTF_CONSTS_VH
`define BLTF_CONSTS_VH

// register byte offsets, one aligned 32-bit word each
`define BLTF_OFF_CTRL 8'h00
`define BLTF_OFF_TX_UPD 8'h04
`define BLTF_OFF_TX_STS 8'h08
`define BLTF_OFF_SEED 8'h0C
`define BLTF_OFF_STATUS 8'h10
`define BLTF_OFF_RX_UPD 8'h14
`define BLTF_OFF_RX_STS 8'h18

// writable bits of the control-field registers, reserved bits stay zero
`define BLTF_UPD_MASK 16'h303F
`define BLTF_STS_MASK 16'h803F
`define BLTF_SEED_MASK 11'h7FF
`define BLTF_SEED_RST 11'h7FF

// status register bit positions
`define BLTF_ST_LOCK 0
`define BLTF_ST_TXACT 1
`define BLTF_ST_DMEERR 2
`define BLTF_ST_TECH 3

// frame layout in line bit times
`define BLTF_FRAME_BITS 13'd4384
`define BLTF_MARK_ONES 13'd16
`define BLTF_MARK_END 13'd32
`define BLTF_CTL_END 13'd288
`define BLTF_PRBS_END 13'd4382
`define BLTF_MARKER 32'hFFFF0000

// lock hysteresis defaults
`define BLTF_LOCK_HITS 2
`define BLTF_LOSS_MISS 3

// axi responses
`define BLTF_RESP_OKAY 2'h0
`define BLTF_RESP_SLVERR 2'h2

`endif

// file: dv/bltf_framer_props.sv
/* port assertions for the training framer.
   assumes one aclk domain and that the train enable is never dropped mid-run. */
`timescale 1ns/1ns
module bltf_framer_chk (
  input wire aclk,
  input wire aresetn,
  input wire tech_ready,
  input wire tx_line,
  input wire tx_sof,
  input wire [15:0] rx_update,
  input wire [15:0] rx_status,
  input wire rx_dme_err,
  input wire s_axi_bvalid,
  input wire s_axi_bready
);
  reg [12:0] cnt_r;
  reg seen_r;
  wire [12:0] cnt_nxt = tx_sof ? 13'h0001 : cnt_r + 13'h0001;
  wire [12:0] pos = tx_sof ? 13'h0000 : cnt_r;
  wire in_ctl = (seen_r || tx_sof) && pos >= 13'h0020 && pos < 13'h0120;
  // bit position in frame; restart when training is withheld
  always @(posedge aclk) begin
    if (!aresetn || !tech_ready) begin
      cnt_r <= 13'h0000;
      seen_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      seen_r <= seen_r | tx_sof;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_ones; tx_line [*8] ##1 tx_line [*8]; endsequence
  sequence s_zeros; !tx_line [*8] ##1 !tx_line [*8]; endsequence
  property p_frame_len; tx_sof && seen_r |-> cnt_r == 13'h1120; endproperty
  property p_marker; tx_sof |-> s_ones ##1 s_zeros; endproperty
  property p_cell; in_ctl && pos[2:0] == 3'h0 |-> tx_line != $past(tx_line); endproperty
  property p_quarter; in_ctl && pos[1:0] != 2'h0 |-> $stable(tx_line); endproperty
  property p_tail; seen_r && !tx_sof && pos >= 13'h111E |-> !tx_line; endproperty
  property p_idle; !tech_ready && !$past(tech_ready) |-> !tx_line && !tx_sof; endproperty
  property p_rx_resv;
    $changed(rx_update) || $changed(rx_status) |->
      (rx_update & 16'hCFC0) == 16'h0000 && (rx_status & 16'h7FC0) == 16'h0000;
  endproperty
  property p_rx_clean; $changed(rx_update) || $changed(rx_status) |-> !rx_dme_err; endproperty
  property p_err_hold;
    rx_dme_err |=> ($stable(rx_update) && $stable(rx_status) && !rx_dme_err) [*8];
  endproperty
  property p_bresp; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  a_frame_len: assert property (p_frame_len) else $error("frame length off");
  a_marker: assert property (p_marker) else $error("bad frame marker");
  a_cell: assert property (p_cell) else $error("no cell boundary toggle");
  a_quarter: assert property (p_quarter) else $error("level moved inside quarter");
  a_tail: assert property (p_tail) else $error("tail bits not zero");
  a_idle: assert property (p_idle) else $error("line active without technology");
  a_rx_resv: assert property (p_rx_resv) else $error("reserved bit set");
  a_rx_clean: assert property (p_rx_clean) else $error("fields moved on error");
  a_err_hold: assert property (p_err_hold) else $error("fields not held");
  a_bresp: assert property (p_bresp) else $error("write response repeated");
endmodule // bltf_framer_chk

bind bltf_framer bltf_framer_chk u_chk (
  .aclk(aclk),
  .aresetn(aresetn),
  .tech_ready(tech_ready),
  .tx_line(tx_line),
  .tx_sof(tx_sof),
  .rx_update(rx_update),
  .rx_status(rx_status),
  .rx_dme_err(rx_dme_err),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready)
);

// file: dv/bltf_link_partner.sv
/* far-end link partner: sends training frames onto the receive lane.
   assumes aclk is the line bit clock, one bit per cycle. */
`timescale 1ns/1ns
module bltf_link_partner #(
  parameter [10:0] SEED = 11'h2B5
) (
  input wire aclk,
  output logic line
);
  logic [10:0] q_r = SEED; // seeded once, then free-running
  initial line = 1'b0;
  // one line bit per clock, changed just after the edge
  task automatic put(input logic b);
    @(posedge aclk);
    line <= b;
  endtask
  // bad drops one cell-boundary transition, a coding error
  task automatic send_frame(input logic [15:0] upd, input logic [15:0] sts, input logic bad);
    logic [31:0] w;
    logic lvl;
    w = {upd, sts}; // fields frozen for the frame
    lvl = 1'b0;
    for (int i = 0; i < 32; i++) put(i < 16);
    for (int c = 31; c >= 0; c--) begin
      lvl = (bad && c == 27) ? lvl : ~lvl;
      repeat (4) put(lvl);
      lvl = lvl ^ w[c];
      repeat (4) put(lvl);
    end
    for (int i = 0; i < 4094; i++) begin
      put(q_r[10]);
      q_r = {q_r[9:0], q_r[10] ^ q_r[8]};
    end
    put(1'b0);
    put(1'b0);
  endtask
endmodule // bltf_link_partner

// file: dv/test_backplane_training_framer.sv
/* self-checking bench: registers, transmit frames, receive decode.
   assumes the framer header on the include path and the partner model. */
`timescale 1ns/1ns
`include "bltf_consts.vh"
module test_backplane_training_framer;
  logic aclk = 1'b0, aresetn = 1'b0, tech_ready = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h00000000;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire tx_line, tx_sof, rx_line, frame_lock, rx_dme_err;
  wire [15:0] rx_update, rx_status;
  int err_count = 0, compares = 0;
  logic [10:0] lfsr_r;
  logic err_seen_r = 1'b0;
  always #5 aclk = ~aclk;
  // latch any error pulse, it lasts a single cycle
  always @(posedge aclk) if (rx_dme_err === 1'b1) err_seen_r <= 1'b1;
  bltf_framer DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .tech_ready(tech_ready), .tx_line(tx_line), .tx_sof(tx_sof),
    .rx_line(rx_line), .frame_lock(frame_lock), .rx_update(rx_update),
    .rx_status(rx_status), .rx_dme_err(rx_dme_err));
  bltf_link_partner lp (.aclk(aclk), .line(rx_line));
  task automatic final_report;
    if (err_count == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tmo(input string name);
    err_count++;
    $display("ERROR %s expected response seen timeout", name);
    final_report();
  endtask
  // valids drop once taken; bready held until the response
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 64);
    if (n >= 64) tmo("write response");
    s_axi_bready <= 1'b0;
    chk("bresp", s_axi_bresp, er);
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 64);
    if (n >= 64) tmo("read response");
    s_axi_rready <= 1'b0;
    chk("rresp", s_axi_rresp, er);
    chk($sformatf("rdata at %h", a), s_axi_rdata, ed);
  endtask
  // capture one frame at falling edges, leave at the next frame start
  task automatic check_tx(input logic [15:0] eu, input logic [15:0] es);
    logic fb [0:4383];
    logic [31:0] w;
    logic ok;
    int n;
    n = 0;
    while (tx_sof !== 1'b1) begin
      @(negedge aclk);
      n++;
      if (n > 9000) tmo("frame start");
    end
    for (int i = 0; i < 4384; i++) begin
      fb[i] = tx_line;
      @(negedge aclk);
    end
    chk("frame spacing", tx_sof, 1);
    ok = 1'b1;
    for (int i = 0; i < 32; i++) if (fb[i] !== (i < 16)) ok = 1'b0;
    chk("marker", ok, 1);
    for (int c = 0; c < 32; c++) begin
      if (fb[32 + 8 * c] === fb[31 + 8 * c]) ok = 1'b0;
      w[31 - c] = fb[36 + 8 * c] ^ fb[35 + 8 * c];
    end
    chk("cell toggles", ok, 1);
    chk("update field", w[31:16], eu);
    chk("status field", w[15:0], es);
    for (int i = 288; i < 4382; i++) begin
      if (fb[i] !== lfsr_r[10]) ok = 1'b0;
      lfsr_r = {lfsr_r[9:0], lfsr_r[10] ^ lfsr_r[8]};
    end
    chk("training bits", ok, 1);
    chk("tail zeros", {fb[4382], fb[4383]}, 0);
  endtask
  task automatic t_regs;
    chk("frame_lock at reset", frame_lock, 0);
    axi_rd(`BLTF_OFF_STATUS, 32'h00000000, `BLTF_RESP_OKAY);
    axi_rd(`BLTF_OFF_SEED, 32'h000007FF, `BLTF_RESP_OKAY);
    axi_rd(`BLTF_OFF_RX_STS, 32'h00000000, `BLTF_RESP_OKAY);
    axi_rd(8'h1C, 32'h00000000, `BLTF_RESP_SLVERR);
    axi_wr(8'h1C, 32'hFFFFFFFF, `BLTF_RESP_SLVERR);
  endtask
  task automatic t_no_tech;
    int n;
    n = 0;
    axi_wr(`BLTF_OFF_CTRL, 32'h00000001, `BLTF_RESP_OKAY);
    repeat (200) begin
      @(negedge aclk);
      if (tx_sof !== 1'b0 || tx_line !== 1'b0) n++;
    end
    chk("activity without technology", n, 0);
    axi_rd(`BLTF_OFF_STATUS, 32'h00000000, `BLTF_RESP_OKAY);
  endtask
  // reserved bits written as ones must go out as zero
  task automatic t_tx;
    axi_wr(`BLTF_OFF_TX_UPD, 32'h0000FFFF, `BLTF_RESP_OKAY);
    axi_wr(`BLTF_OFF_TX_STS, 32'h0000FFFF, `BLTF_RESP_OKAY);
    axi_wr(`BLTF_OFF_SEED, 32'h00000123, `BLTF_RESP_OKAY);
    axi_rd(`BLTF_OFF_TX_UPD, 32'h0000303F, `BLTF_RESP_OKAY);
    lfsr_r = 11'h123;
    @(posedge aclk);
    tech_ready <= 1'b1;
    check_tx(16'h303F, 16'h803F);
    fork
      check_tx(16'h303F, 16'h803F);
      begin
        axi_wr(`BLTF_OFF_TX_UPD, 32'h00002024, `BLTF_RESP_OKAY);
        axi_wr(`BLTF_OFF_TX_STS, 32'h00000006, `BLTF_RESP_OKAY);
      end
    join
    check_tx(16'h2024, 16'h0006);
    axi_rd(`BLTF_OFF_STATUS, 32'h0000000A, `BLTF_RESP_OKAY);
  endtask
  task automatic t_rx;
    int n;
    n = 0;
    repeat (3) lp.send_frame(16'hFFFF, 16'hFFFF, 1'b0);
    chk("frame_lock", frame_lock, 1);
    chk("rx_update", rx_update, 16'h303F);
    chk("rx_status", rx_status, 16'h803F);
    lp.send_frame(16'h1009, 16'h0021, 1'b1);
    chk("error pulse", err_seen_r, 1);
    chk("rx_update held", rx_update, 16'h303F);
    chk("rx_status held", rx_status, 16'h803F);
    fork
      lp.send_frame(16'h1009, 16'h0021, 1'b0);
      begin
        axi_rd(`BLTF_OFF_STATUS, 32'h0000000F, `BLTF_RESP_OKAY);
        axi_wr(`BLTF_OFF_STATUS, 32'h00000004, `BLTF_RESP_OKAY);
        axi_rd(`BLTF_OFF_STATUS, 32'h0000000B, `BLTF_RESP_OKAY);
      end
    join
    chk("rx_update", rx_update, 16'h1009);
    axi_rd(`BLTF_OFF_RX_STS, 32'h00000021, `BLTF_RESP_OKAY);
    while (frame_lock === 1'b1 && n < 20000) begin
      @(negedge aclk);
      n++;
    end
    chk("lock after missed markers", frame_lock, 0);
  endtask
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_no_tech();
    t_tx();
    t_rx();
    final_report();
  end
endmodule // test_backplane_training_framer
